// ---- verilog/ccr_readout.sv ----
// Overview of operation
// - two-bit read-only converter mode, reset zero
// - mode codes: down, auto, up, linear parallel
// - mode register frozen while it is addressed
// - high count byte at 0x13, reset zero
// - each count equals prescaled converter pulses
// - counter frozen while addressed, pulses dropped
// - high read copies low byte to shadow
// - low count byte at 0x14, reset zero
`timescale 1ns/1ps
`include "ccr_params.svh"

module ccr_readout (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           clk_en,
  input  wire ccr_pkg::ccr_req_t  req,
  input  wire ccr_pkg::ccr_conv_t conv,
  output logic [7:0]          rd_data,
  output logic                rd_valid
);
  import ccr_pkg::*;

  // how the block hangs together:
  // - the converter pulse and the live mode come from another
  //   domain, so each passes two flops before any logic reads it
  // - a pulse counts on its synchronised rising edge only, so a
  //   long high level is one pulse and never several
  // - the prescaler gathers count_prescale + 1 pulses into one
  //   unit of the charge counter
  // - addressing 0x13 or 0x14 freezes counter and prescaler; pulses
  //   that arrive then are dropped on purpose, never queued, so a
  //   host that keeps the offset addressed loses charge
  // - addressing 0x12 freezes the visible mode field in the same
  //   way, so a capture cannot see a half-changed mode
  // - a read of 0x13 copies the live low byte into a shadow; 0x14
  //   always returns the shadow, never the live byte, which keeps
  //   a high-then-low pair coherent
  // - clk_en low holds every flop, synchronisers included

  // true when a request addresses the given offset
  function automatic logic hits(input ccr_req_t r, input logic [7:0] ofs);
    hits = r.sel && (r.addr == ofs);
  endfunction : hits

  // synchronisers for the asynchronous converter signals
  logic           pulse_s1_q;      // first stage, read only by second
  logic           pulse_s2_q;      // synchronised pulse
  logic           pulse_prev_q;    // delayed copy for edge detect
  logic [1:0]     mode_s1_q;       // first stage of mode
  logic [1:0]     mode_s2_q;       // synchronised mode
  ccr_conv_mode_t mode_q;          // visible mode field
  logic [3:0]     pre_q;           // pulses seen in current unit
  logic [15:0]    count_q;         // charge counter
  logic [7:0]     shadow_q;        // low byte captured on high read
  logic [7:0]     rd_data_q;       // read data
  logic           rd_valid_q;      // read data valid

  // decoded accesses; each holds for the whole addressing time,
  // not only for the cycle of the read strobe
  wire mode_addr  = hits(req, `CCR_OFS_MODE);
  wire high_addr  = hits(req, `CCR_OFS_HIGH);
  wire low_addr   = hits(req, `CCR_OFS_LOW);
  wire mode_frz   = mode_addr;
  wire count_frz  = high_addr | low_addr;
  // rising edge of the synchronised pulse; history resets low,
  // the idle level of the pin, so no false edge follows reset
  wire pulse_edge = pulse_s2_q & ~pulse_prev_q;
  // last pulse of a prescaler unit
  wire unit_done  = pulse_edge && (pre_q == conv.count_prescale);
  // the two halves of the counter as the host sees them
  wire [7:0] cnt_hi = count_q[15:8];
  wire [7:0] cnt_lo = count_q[7:0];

  // read mux; unmapped offsets return zero
  wire [7:0] rd_mux =
    mode_addr ? {6'h00, mode_q} :
    high_addr ? cnt_hi :
    low_addr  ? shadow_q :
                `CCR_UNMAPPED;

  // two-flop synchronisers and edge history
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      // all stages reset to the idle level of their pins
      pulse_s1_q   <= 1'b0;
      pulse_s2_q   <= 1'b0;
      pulse_prev_q <= 1'b0;
      mode_s1_q    <= 2'h0;
      mode_s2_q    <= 2'h0;
    end else if (clk_en) begin
      // first stage may go metastable; only the second reads it
      pulse_s1_q   <= conv.pfm_pulse;
      pulse_s2_q   <= pulse_s1_q;
      pulse_prev_q <= pulse_s2_q;
      mode_s1_q    <= conv.converter_mode;
      mode_s2_q    <= mode_s1_q;
    end
  end

  // mode field tracks converter unless addressed; the mode is a
  // multi-bit word, so a change may pass one odd code for a cycle,
  // which the freeze keeps away from a capture in progress
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_q <= ccr_conv_mode_t'(`CCR_RST_MODE);
    end else if (clk_en && !mode_frz) begin
      mode_q <= ccr_conv_mode_t'(mode_s2_q);
    end
  end

  // prescaler and counter; pulses while frozen are lost
  // the counter wraps from all ones to zero, as the host expects
  // of a free running charge count
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_q   <= `CCR_RST_PRE;
      count_q <= `CCR_RST_COUNT;
    end else if (clk_en && !count_frz && pulse_edge) begin
      if (unit_done) begin
        // unit complete: restart prescaler, step the counter
        pre_q   <= `CCR_RST_PRE;
        count_q <= count_q + 16'h0001;
      end else begin
        // unit still open: one more pulse gathered
        pre_q   <= pre_q + 4'h1;
      end
    end
  end

  // shadow capture on high byte read; the counter is frozen while
  // 0x13 is addressed, so the low byte matches the high byte read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow_q <= `CCR_RST_BYTE;
    end else if (clk_en && req.rd && high_addr) begin
      shadow_q <= cnt_lo;
    end
  end

  // registered read data; data holds until the next taken read
  // and valid pulses one cycle after each taken read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data_q  <= `CCR_RST_BYTE;
      rd_valid_q <= 1'b0;
    end else if (clk_en) begin
      rd_valid_q <= req.rd;
      if (req.rd) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_mode_track: assert property (clk_en && !mode_frz |=>
    mode_q == $past(mode_s2_q)) else $error("mode not tracking");
  a_mode_read: assert property (clk_en && req.rd && mode_addr |=>
    rd_data_q[7:2] == 6'h00 && rd_data_q[1:0] == $past(mode_q))
    else $error("mode read wrong");
  a_mode_hold: assert property (clk_en && mode_frz |=>
    $stable(mode_q)) else $error("mode changed while addressed");
  a_high_read: assert property (clk_en && req.rd && high_addr |=>
    rd_data_q == $past(cnt_hi)) else $error("high byte read wrong");
  a_count_step: assert property (clk_en && !count_frz && unit_done |=>
    count_q == $past(count_q) + 16'h0001) else $error("count no step");
  a_pre_bound: assert property (pulse_edge && !unit_done &&
    clk_en && !count_frz |=> count_q == $past(count_q))
    else $error("count stepped early");
  a_count_freeze: assert property (clk_en && count_frz |=>
    $stable(count_q) && $stable(pre_q)) else $error("count not frozen");
  a_shadow_cap: assert property (clk_en && req.rd && high_addr |=>
    shadow_q == $past(cnt_lo)) else $error("shadow not captured");
  a_low_read: assert property (clk_en && req.rd && low_addr |=>
    rd_data_q == $past(shadow_q)) else $error("low byte read wrong");
  // a back to back pair must return the low byte of the high read
  a_pair_read: assert property (clk_en && req.rd && high_addr ##1
    clk_en && req.rd && low_addr && !(clk_en && req.rd && high_addr)
    |=> rd_data_q == $past(cnt_lo, 2)) else $error("pair incoherent");
  // every taken read is answered by one valid pulse
  a_valid_pulse: assert property (clk_en |=>
    rd_valid_q == $past(req.rd)) else $error("valid pulse wrong");
  // clock enable low holds count, shadow, mode and read data
  a_enable_hold: assert property (!clk_en |=>
    $stable(count_q) && $stable(shadow_q) && $stable(mode_q) &&
    $stable(rd_data_q)) else $error("state moved while disabled");

  c_pair: cover property (req.rd && high_addr ##[1:4] req.rd && low_addr);
  c_mode: cover property (req.rd && mode_addr);
  c_step: cover property (clk_en && unit_done && !count_frz);
  c_lost: cover property (clk_en && count_frz && pulse_edge);
  c_held: cover property (!clk_en && pulse_edge);

endmodule : ccr_readout

// ---- common/ccr_params.svh ----
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// register offsets
`define CCR_OFS_MODE   8'h12
`define CCR_OFS_HIGH   8'h13
`define CCR_OFS_LOW    8'h14

// mode field position
`define CCR_MODE_MSB   1
`define CCR_MODE_LSB   0

// reset values
`define CCR_RST_MODE   2'h0
`define CCR_RST_BYTE   8'h00
`define CCR_RST_COUNT  16'h0000
`define CCR_RST_PRE    4'h0

// read data for unmapped offsets
`define CCR_UNMAPPED   8'h00

`endif

// ---- common/ccr_pkg.sv ----
package ccr_pkg;

  // converter mode driving output_a
  typedef enum logic [1:0] {
    CCR_STEP_DOWN,
    CCR_AUTO_UPDOWN,
    CCR_STEP_UP,
    CCR_LINEAR_PARALLEL
  } ccr_conv_mode_t;

  // register access from the serial interface
  typedef struct packed {
    logic [7:0] addr;  // register offset
    logic       sel;   // offset currently addressed
    logic       rd;    // read strobe, one cycle
  } ccr_req_t;

  // converter side signals
  typedef struct packed {
    logic       pfm_pulse;      // converter pulse, asynchronous
    logic [1:0] converter_mode; // live mode, asynchronous
    logic [3:0] count_prescale; // pulses per count minus one
  } ccr_conv_t;

endpackage : ccr_pkg

// ---- dv/ccr_readout_tb.sv ----
`timescale 1ns/1ps
module ccr_readout_tb;
  import ccr_pkg::*;
  logic       clk;
  logic       rst_b;
  logic       clk_en;
  logic       rd_valid;
  logic [7:0] rd_data;
  ccr_req_t   req;
  ccr_conv_t  conv;
  int error_cnt, n_compared, cyc, cnt, pre, pul, m;
  ccr_readout DUT (
    .clk      (clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .req      (req),
    .conv     (conv),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );
  // free running clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // counts, then verdict
  task automatic end_sim();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // byte compare
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one read; answer seen the cycle after the taking edge
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge clk);
    req = '{addr: a, sel: 1'b1, rd: 1'b1};
    @(negedge clk);
    req.rd = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rd_data", e, rd_data);
    req.sel = 1'b0;
  endtask : rd
  // converter pulses, two cycles high and at least three low each
  task automatic pulse(int n);
    repeat (n) begin
      @(negedge clk) conv.pfm_pulse = 1'b1;
      repeat (2) @(negedge clk);
      conv.pfm_pulse = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (5) @(negedge clk);
  endtask : pulse
  initial begin
    void'($urandom(32'hBC6F));
    clk_en = 1'b1;
    rst_b = 1'b0;
    req = '0;
    conv = '0;
    pre = $urandom_range(1);
    conv.count_prescale = pre[3:0];
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h14, 8'h00);
    rd(8'h20, 8'h00);
    // every mode code in turn
    for (m = 0; m < 4; m++) begin
      conv.converter_mode = m[1:0];
      repeat (5) @(negedge clk);
      rd(8'h12, {6'h00, m[1:0]});
    end
    // mode held while its offset stays addressed
    req = '{addr: 8'h12, sel: 1'b1, rd: 1'b0};
    conv.converter_mode = 2'h1;
    repeat (8) @(negedge clk);
    rd(8'h12, 8'h03);
    // count past one byte, then check the shadow
    pul = 520 + $urandom_range(60);
    pulse(pul);
    cnt = pul / (pre + 1);
    rd(8'h13, cnt[15:8]);
    pulse(pre + 1);
    rd(8'h14, cnt[7:0]);
    cnt = (pul + pre + 1) / (pre + 1);
    // pulses while addressed are lost
    req = '{addr: 8'h13, sel: 1'b1, rd: 1'b0};
    pulse(3);
    rd(8'h13, cnt[15:8]);
    rd(8'h14, cnt[7:0]);
    rd(8'h12, 8'h01);
    // clock enable low freezes the count
    clk_en = 1'b0;
    pulse(pre + 1);
    clk_en = 1'b1;
    rd(8'h13, cnt[15:8]);
    rd(8'h14, cnt[7:0]);
    // reset in mid-run clears count and shadow
    @(negedge clk) rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h14, 8'h00);
    rd(8'h13, 8'h00);
    end_sim();
  end
endmodule : ccr_readout_tb
